// ---- hw/mac_pkg.sv ----
/*
  Types and constants for the multiply and accumulate datapath.
  Assumes one core clock and a synchronous active-high reset.
*/
package mac_pkg;

  // ----------------------------------------------------------------
  // Widths
  // ----------------------------------------------------------------
  localparam int OPND_W = 16;
  localparam int MULT_W = 17;
  localparam int PROD_W = 33;
  localparam int ACC_W = 40;
  localparam int GUARD_LO = 32;
  localparam int SIGN31 = 31;

  // ----------------------------------------------------------------
  // Register byte offsets
  // ----------------------------------------------------------------
  localparam logic [7:0] OFS_CORE_CONTROL = 8'h00;
  localparam logic [7:0] OFS_INT_CONTROL_ONE = 8'h04;
  localparam logic [7:0] OFS_ARITH_FLAGS = 8'h08;
  localparam logic [7:0] OFS_EVENT_STATUS = 8'h0C;
  localparam logic [7:0] OFS_EVENT_MASK = 8'h10;
  localparam logic [7:0] OFS_ACC_A_LOW = 8'h14;
  localparam logic [7:0] OFS_ACC_A_HIGH = 8'h18;
  localparam logic [7:0] OFS_ACC_B_LOW = 8'h1C;
  localparam logic [7:0] OFS_ACC_B_HIGH = 8'h20;
  localparam logic [7:0] OFS_PRODUCT = 8'h24;

  // ----------------------------------------------------------------
  // Field positions
  // ----------------------------------------------------------------
  localparam int CTRL_CLIP_EN_A = 7;
  localparam int CTRL_CLIP_EN_B = 6;
  localparam int CTRL_LIMIT_SEL = 4;
  localparam int TRAP_EN_A_BIT = 0;
  localparam int TRAP_EN_B_BIT = 1;
  // Flag and event layout: guard A, guard B, clipped A, clipped B
  localparam int FLAG_GUARD_A = 0;
  localparam int FLAG_GUARD_B = 1;
  localparam int FLAG_CLIP_A = 2;
  localparam int FLAG_CLIP_B = 3;
  localparam int FLAG_EITHER_GUARD = 4;
  localparam int FLAG_EITHER_CLIP = 5;

  localparam logic [1:0] RESP_OKAY = 2'h0;
  localparam logic [1:0] RESP_SLVERR = 2'h2;

  // ----------------------------------------------------------------
  // Operations
  // ----------------------------------------------------------------
  typedef enum logic [2:0] {
    OP_MAC = 3'h0,
    OP_MSC = 3'h1,
    OP_MPY = 3'h2,
    OP_ADD = 3'h3,
    OP_SUB = 3'h4,
    OP_LOAD = 3'h5,
    OP_INT_PRODUCT = 3'h6,
    OP_NONE = 3'h7
  } op_type;

  typedef struct packed {
    logic valid;
    op_type op;
    logic acc_sel;
    logic signed_a;
    logic signed_b;
    logic frac;
    logic byte_size;
    logic use_shifted;
    logic [OPND_W-1:0] opnd_a;
    logic [OPND_W-1:0] opnd_b;
    logic [ACC_W-1:0] data_in;
    logic [ACC_W-1:0] shifted_in;
  } op_req_type;

  typedef struct packed {
    logic [ACC_W-1:0] acc_a;
    logic [ACC_W-1:0] acc_b;
    logic [31:0] product;
    logic product_valid;
    logic [3:0] flags;
    logic clip_en_a;
    logic clip_en_b;
    logic limit_sel;
    logic trap_en_a;
    logic trap_en_b;
    logic [3:0] events;
    logic [3:0] mask;
    logic aw_got;
    logic [7:0] awaddr;
    logic w_got;
    logic [31:0] wdata;
    logic [3:0] wstrb;
    logic bvalid;
    logic [1:0] bresp;
    logic rvalid;
    logic [31:0] rdata;
    logic [1:0] rresp;
  } state_type;

  localparam state_type STATE_RESET = '0;

endpackage

// ---- hw/dsp_multiply_accumulate.sv ----
/*
  Multiply and accumulate datapath: 17x17 multiplier with scaler,
  40-bit adder/subtracter on two accumulators, saturation, overflow
  flags, arithmetic trap and an AXI4-Lite register slave.
  Assumes the core decode presents one operation per cycle on op_req,
  already scaled by the external barrel shifter where asked.
*/
// How it works
// - 17-bit multiplier, fractional or integer result
// - Operands widened by zero or sign bit
// - 33-bit product sign-extended to forty bits
// - Fractional mode doubles product into 1.31
// - Signed, unsigned and mixed integer multiplies
// - Byte gives 16-bit, word 32-bit product
// - 40-bit adder on selected accumulator A/B
// - Add/load data optionally from barrel shifter
// - Zeroable first input, true/complement second
// - Carry in low for add, high for subtract
// - Detect overflow out of bit 39
// - Guard spill when bits 32-39 differ
// - Saturation from result, flags, control bits
// - Clipped flag set when accumulator saturates
// - Either flags are OR of both accumulators
// - Guard spill updated every adder operation
// - Guard spill plus enable raises trap
// - Flags latched and readable in status
module dsp_multiply_accumulate
  import mac_pkg::*;
(
  // Clock and reset
  input wire logic mclk,
  input wire logic rst,
  // Operation from core decode
  input op_req_type op_req,
  // Results
  output logic [ACC_W-1:0] acc_a,
  output logic [ACC_W-1:0] acc_b,
  output logic [31:0] product,
  output logic product_valid,
  output logic [5:0] status_flags,
  output logic arith_trap,
  output logic irq,
  // AXI4-Lite write
  input wire logic [7:0] s_axi_awaddr,
  input wire logic s_axi_awvalid,
  output logic s_axi_awready,
  input wire logic [31:0] s_axi_wdata,
  input wire logic [3:0] s_axi_wstrb,
  input wire logic s_axi_wvalid,
  output logic s_axi_wready,
  output logic [1:0] s_axi_bresp,
  output logic s_axi_bvalid,
  input wire logic s_axi_bready,
  // AXI4-Lite read
  input wire logic [7:0] s_axi_araddr,
  input wire logic s_axi_arvalid,
  output logic s_axi_arready,
  output logic [31:0] s_axi_rdata,
  output logic [1:0] s_axi_rresp,
  output logic s_axi_rvalid,
  input wire logic s_axi_rready
);

  state_type s_r;
  state_type s_nxt;

  // ----------------------------------------------------------------
  // Helpers
  // ----------------------------------------------------------------
  function automatic logic [31:0] merge_bytes(input logic [31:0] old_v,
                                              input logic [31:0] new_v,
                                              input logic [3:0] strb);
    logic [31:0] res;
    res = old_v;
    for (int i = 0; i < 4; i++)
    begin
      if (strb[i])
      begin
        res[i*8 +: 8] = new_v[i*8 +: 8];
      end
    end
    return res;
  endfunction

  // ----------------------------------------------------------------
  // Multiplier and scaler
  // ----------------------------------------------------------------
  logic [OPND_W-1:0] opa16;
  logic [OPND_W-1:0] opb16;
  logic [MULT_W-1:0] mul_a;
  logic [MULT_W-1:0] mul_b;
  logic signed [2*MULT_W-1:0] prod_full;
  logic [PROD_W-1:0] prod33;
  logic [ACC_W-1:0] prod40;

  always_comb
  begin
    // Byte operands are first extended to a word of their own sign
    if (op_req.byte_size && op_req.op == OP_INT_PRODUCT)
    begin
      opa16 = {{8{op_req.signed_a & op_req.opnd_a[7]}}, op_req.opnd_a[7:0]};
      opb16 = {{8{op_req.signed_b & op_req.opnd_b[7]}}, op_req.opnd_b[7:0]};
    end
    else
    begin
      opa16 = op_req.opnd_a;
      opb16 = op_req.opnd_b;
    end
    mul_a = {op_req.signed_a & opa16[OPND_W-1], opa16};
    mul_b = {op_req.signed_b & opb16[OPND_W-1], opb16};
    prod_full = $signed(mul_a) * $signed(mul_b);
    // Fractional doubling drops the duplicate sign bit
    if (op_req.frac && op_req.op != OP_INT_PRODUCT)
    begin
      prod33 = {prod_full[PROD_W-2:0], 1'b0};
    end
    else
    begin
      prod33 = prod_full[PROD_W-1:0];
    end
    prod40 = {{(ACC_W-PROD_W){prod33[PROD_W-1]}}, prod33};
  end

  // ----------------------------------------------------------------
  // Adder/subtracter and saturation
  // ----------------------------------------------------------------
  logic is_acc_op;
  logic is_sub;
  logic zero_in;
  logic [ACC_W-1:0] src_acc;
  logic [ACC_W-1:0] add_x;
  logic [ACC_W-1:0] add_y;
  logic [ACC_W:0] y_ext;
  logic [ACC_W:0] sum41;
  logic [ACC_W-1:0] raw;
  logic ov39;
  logic ov31;
  logic guard;
  logic true_neg;
  logic clip_en;
  logic do_clip;
  logic [ACC_W-1:0] result;

  always_comb
  begin
    is_acc_op = op_req.valid && op_req.op != OP_INT_PRODUCT && op_req.op != OP_NONE;
    is_sub = (op_req.op == OP_MSC) || (op_req.op == OP_SUB);
    zero_in = (op_req.op == OP_MPY) || (op_req.op == OP_LOAD);
    src_acc = op_req.acc_sel ? s_r.acc_b : s_r.acc_a;
    add_x = zero_in ? '0 : src_acc;
    case (op_req.op)
      OP_ADD, OP_SUB, OP_LOAD:
      begin
        add_y = op_req.use_shifted ? op_req.shifted_in : op_req.data_in;
      end
      default:
      begin
        add_y = prod40;
      end
    endcase
    // Subtract as complement plus an inverted borrow of one
    y_ext = is_sub ? ~{add_y[ACC_W-1], add_y} : {add_y[ACC_W-1], add_y};
    sum41 = {add_x[ACC_W-1], add_x} + y_ext + {{ACC_W{1'b0}}, is_sub};
    raw = sum41[ACC_W-1:0];
    ov39 = sum41[ACC_W] ^ sum41[ACC_W-1];
    guard = ~((&raw[ACC_W-1:GUARD_LO]) | ~(|raw[ACC_W-1:GUARD_LO]));
    ov31 = ~((&raw[ACC_W-1:SIGN31]) | ~(|raw[ACC_W-1:SIGN31]));
    // Bit 40 keeps the true sign even when bit 39 has wrapped
    true_neg = sum41[ACC_W];
    clip_en = op_req.acc_sel ? s_r.clip_en_b : s_r.clip_en_a;
    do_clip = clip_en && (s_r.limit_sel ? ov39 : (ov39 || ov31));
    result = raw;
    if (do_clip)
    begin
      if (s_r.limit_sel)
      begin
        result = true_neg ? {1'b1, {(ACC_W-1){1'b0}}} : {1'b0, {(ACC_W-1){1'b1}}};
      end
      else
      begin
        result = true_neg ? {{(ACC_W-SIGN31){1'b1}}, {SIGN31{1'b0}}}
                          : {{(ACC_W-SIGN31){1'b0}}, {SIGN31{1'b1}}};
      end
    end
  end

  // ----------------------------------------------------------------
  // Next state
  // ----------------------------------------------------------------
  logic [3:0] op_events;
  logic wr_fire;
  logic [31:0] wval;
  logic [31:0] rd_word;
  logic rd_hit;

  always_comb
  begin
    s_nxt = s_r;
    op_events = '0;
    wr_fire = s_r.aw_got && s_r.w_got && !s_r.bvalid;
    wval = '0;
    rd_word = '0;
    rd_hit = 1'b1;

    // Datapath
    s_nxt.product_valid = 1'b0;
    if (op_req.valid && op_req.op == OP_INT_PRODUCT)
    begin
      // Byte result occupies the low half only
      s_nxt.product = op_req.byte_size ? {16'h0000, prod33[15:0]} : prod33[31:0];
      s_nxt.product_valid = 1'b1;
    end
    if (is_acc_op)
    begin
      if (op_req.acc_sel)
      begin
        s_nxt.acc_b = result;
        s_nxt.flags[FLAG_GUARD_B] = guard;
        op_events[FLAG_GUARD_B] = guard;
        op_events[FLAG_CLIP_B] = do_clip;
      end
      else
      begin
        s_nxt.acc_a = result;
        s_nxt.flags[FLAG_GUARD_A] = guard;
        op_events[FLAG_GUARD_A] = guard;
        op_events[FLAG_CLIP_A] = do_clip;
      end
    end

    // Write channel: address and data taken in either order
    if (s_axi_awvalid && s_axi_awready)
    begin
      s_nxt.aw_got = 1'b1;
      s_nxt.awaddr = s_axi_awaddr;
    end
    if (s_axi_wvalid && s_axi_wready)
    begin
      s_nxt.w_got = 1'b1;
      s_nxt.wdata = s_axi_wdata;
      s_nxt.wstrb = s_axi_wstrb;
    end
    if (wr_fire)
    begin
      s_nxt.aw_got = 1'b0;
      s_nxt.w_got = 1'b0;
      s_nxt.bvalid = 1'b1;
      s_nxt.bresp = RESP_OKAY;
      case ({s_r.awaddr[7:2], 2'b00})
        OFS_CORE_CONTROL:
        begin
          wval = merge_bytes({24'h000000, s_r.clip_en_a, s_r.clip_en_b, 1'b0,
                              s_r.limit_sel, 4'h0}, s_r.wdata, s_r.wstrb);
          s_nxt.clip_en_a = wval[CTRL_CLIP_EN_A];
          s_nxt.clip_en_b = wval[CTRL_CLIP_EN_B];
          s_nxt.limit_sel = wval[CTRL_LIMIT_SEL];
        end
        OFS_INT_CONTROL_ONE:
        begin
          wval = merge_bytes({30'h00000000, s_r.trap_en_b, s_r.trap_en_a},
                             s_r.wdata, s_r.wstrb);
          s_nxt.trap_en_a = wval[TRAP_EN_A_BIT];
          s_nxt.trap_en_b = wval[TRAP_EN_B_BIT];
        end
        OFS_ARITH_FLAGS:
        begin
          // Clipped flags stay until software writes a one
          wval = merge_bytes(32'h00000000, s_r.wdata, s_r.wstrb);
          s_nxt.flags[FLAG_CLIP_B:FLAG_CLIP_A] =
            s_r.flags[FLAG_CLIP_B:FLAG_CLIP_A] & ~wval[FLAG_CLIP_B:FLAG_CLIP_A];
        end
        OFS_EVENT_STATUS:
        begin
          wval = merge_bytes(32'h00000000, s_r.wdata, s_r.wstrb);
          s_nxt.events = s_r.events & ~wval[3:0];
        end
        OFS_EVENT_MASK:
        begin
          wval = merge_bytes({28'h0000000, s_r.mask}, s_r.wdata, s_r.wstrb);
          s_nxt.mask = wval[3:0];
        end
        OFS_ACC_A_LOW, OFS_ACC_A_HIGH, OFS_ACC_B_LOW, OFS_ACC_B_HIGH, OFS_PRODUCT:
        begin
          s_nxt.bresp = RESP_OKAY;
        end
        default:
        begin
          s_nxt.bresp = RESP_SLVERR;
        end
      endcase
    end
    if (s_r.bvalid && s_axi_bready)
    begin
      s_nxt.bvalid = 1'b0;
    end

    // Hardware set wins over a software clear in the same cycle
    s_nxt.flags[FLAG_CLIP_A] = s_nxt.flags[FLAG_CLIP_A] | op_events[FLAG_CLIP_A];
    s_nxt.flags[FLAG_CLIP_B] = s_nxt.flags[FLAG_CLIP_B] | op_events[FLAG_CLIP_B];
    s_nxt.events = s_nxt.events | op_events;

    // Read channel
    case ({s_axi_araddr[7:2], 2'b00})
      OFS_CORE_CONTROL:
      begin
        rd_word = {24'h000000, s_r.clip_en_a, s_r.clip_en_b, 1'b0, s_r.limit_sel, 4'h0};
      end
      OFS_INT_CONTROL_ONE:
      begin
        rd_word = {30'h00000000, s_r.trap_en_b, s_r.trap_en_a};
      end
      OFS_ARITH_FLAGS:
      begin
        rd_word = {26'h0, status_flags};
      end
      OFS_EVENT_STATUS:
      begin
        rd_word = {28'h0000000, s_r.events};
      end
      OFS_EVENT_MASK:
      begin
        rd_word = {28'h0000000, s_r.mask};
      end
      OFS_ACC_A_LOW:
      begin
        rd_word = s_r.acc_a[31:0];
      end
      OFS_ACC_A_HIGH:
      begin
        rd_word = {{24{s_r.acc_a[ACC_W-1]}}, s_r.acc_a[ACC_W-1:32]};
      end
      OFS_ACC_B_LOW:
      begin
        rd_word = s_r.acc_b[31:0];
      end
      OFS_ACC_B_HIGH:
      begin
        rd_word = {{24{s_r.acc_b[ACC_W-1]}}, s_r.acc_b[ACC_W-1:32]};
      end
      OFS_PRODUCT:
      begin
        rd_word = s_r.product;
      end
      default:
      begin
        rd_hit = 1'b0;
      end
    endcase
    if (s_axi_arvalid && s_axi_arready)
    begin
      s_nxt.rvalid = 1'b1;
      s_nxt.rdata = rd_word;
      s_nxt.rresp = rd_hit ? RESP_OKAY : RESP_SLVERR;
    end
    else if (s_r.rvalid && s_axi_rready)
    begin
      s_nxt.rvalid = 1'b0;
    end
  end

  // ----------------------------------------------------------------
  // State register
  // ----------------------------------------------------------------
  always_ff @(posedge mclk)
  begin
    if (rst)
    begin
      s_r <= STATE_RESET;
    end
    else
    begin
      s_r <= s_nxt;
    end
  end

  // ----------------------------------------------------------------
  // Outputs
  // ----------------------------------------------------------------
  assign acc_a = s_r.acc_a;
  assign acc_b = s_r.acc_b;
  assign product = s_r.product;
  assign product_valid = s_r.product_valid;
  assign status_flags = {s_r.flags[FLAG_CLIP_A] | s_r.flags[FLAG_CLIP_B],
                         s_r.flags[FLAG_GUARD_A] | s_r.flags[FLAG_GUARD_B],
                         s_r.flags};
  assign arith_trap = (s_r.flags[FLAG_GUARD_A] & s_r.trap_en_a) |
                      (s_r.flags[FLAG_GUARD_B] & s_r.trap_en_b);
  assign irq = |(s_r.events & s_r.mask);
  // One write in flight: stop taking halves until the response drains
  assign s_axi_awready = !s_r.aw_got && !s_r.bvalid;
  assign s_axi_wready = !s_r.w_got && !s_r.bvalid;
  assign s_axi_bvalid = s_r.bvalid;
  assign s_axi_bresp = s_r.bresp;
  assign s_axi_arready = !s_r.rvalid;
  assign s_axi_rvalid = s_r.rvalid;
  assign s_axi_rdata = s_r.rdata;
  assign s_axi_rresp = s_r.rresp;

endmodule

// ---- bench/mac_properties.sv ----
/*
  Port assertions for the multiply and accumulate datapath.
  Assumes it is bound onto every instance of the datapath.
*/
module mac_properties
  import mac_pkg::*;
(
  // Clock and reset
  input wire logic mclk,
  input wire logic rst,
  // Watched ports
  input op_req_type op_req,
  input logic [ACC_W-1:0] acc_a,
  input logic [ACC_W-1:0] acc_b,
  input logic product_valid,
  input logic [5:0] status_flags,
  input logic arith_trap,
  input logic s_axi_bvalid,
  input wire logic s_axi_bready,
  input logic s_axi_rvalid,
  input logic s_axi_arready
);
  timeunit 1ns;
  timeprecision 1ns;
  // ------------------------------------------------------------
  // Helpers
  // ------------------------------------------------------------
  default clocking @(posedge mclk); endclocking
  default disable iff (rst);
  wire ld_a = op_req.valid && op_req.op == OP_LOAD && !op_req.acc_sel && !op_req.use_shifted;
  wire g_eq = op_req.data_in[39:32] == 8'h0 || op_req.data_in[39:32] == 8'hFF;
  // Within 32-bit range no clip can change the load
  wire fits = g_eq && op_req.data_in[31] == op_req.data_in[32];
  wire mpy_b = op_req.valid && op_req.op == OP_MPY && op_req.acc_sel && !op_req.frac
    && !op_req.signed_a && !op_req.signed_b && !op_req.opnd_a[15];
  wire ip = op_req.valid && op_req.op == OP_INT_PRODUCT;
  // ------------------------------------------------------------
  // Properties
  // ------------------------------------------------------------
  a_either_guard: assert property (status_flags[4] == (status_flags[0] | status_flags[1]))
    else $error("either guard bit wrong");
  a_either_clip: assert property (status_flags[5] == (|status_flags[3:2]))
    else $error("either clipped bit wrong");
  a_load_value: assert property (ld_a && fits |=> acc_a == $past(op_req.data_in))
    else $error("load value wrong");
  a_guard_set: assert property (ld_a && !g_eq |=> status_flags[0])
    else $error("guard spill not flagged");
  a_guard_drop: assert property (ld_a && g_eq |=> !status_flags[0])
    else $error("guard spill not cleared");
  a_mpy_value: assert property (mpy_b |=>
    acc_b == {24'h0, $past(op_req.opnd_a)} * {24'h0, $past(op_req.opnd_b)})
    else $error("unsigned multiply wrong");
  a_pulse_once: assert property (ip |=> product_valid ##1 !product_valid || $past(ip))
    else $error("product valid pulse wrong");
  a_trap_quiet: assert property (!status_flags[0] && !status_flags[1] |-> !arith_trap)
    else $error("trap without guard spill");
  a_b_hold: assert property (s_axi_bvalid && !s_axi_bready |=> s_axi_bvalid)
    else $error("write response dropped");
  a_r_block: assert property (s_axi_rvalid |-> !s_axi_arready)
    else $error("read address taken while busy");
  c_guard: cover property (ld_a && !g_eq);
  c_prod: cover property (ip);
  c_clip: cover property (status_flags[5]);
endmodule

bind dsp_multiply_accumulate mac_properties props_u (
  .mclk(mclk), .rst(rst), .op_req(op_req), .acc_a(acc_a), .acc_b(acc_b),
  .product_valid(product_valid), .status_flags(status_flags), .arith_trap(arith_trap),
  .s_axi_bvalid(s_axi_bvalid), .s_axi_bready(s_axi_bready), .s_axi_rvalid(s_axi_rvalid),
  .s_axi_arready(s_axi_arready)
);

// ---- bench/core_decode_model.sv ----
/*
  Core decode model: presents one operation per cycle on op_req.
  Assumes the datapath never stalls.
*/
module core_decode_model
  import mac_pkg::*;
(
  // Clock
  input wire logic mclk,
  // Operation out
  output op_req_type op_req
);
  timeunit 1ns;
  timeprecision 1ns;
  initial op_req = '0;
  // No handshake, so back to back calls give one op each cycle
  task automatic issue(input op_req_type r);
    @(posedge mclk);
    op_req <= r;
  endtask
endmodule

// ---- bench/dsp_multiply_accumulate_tb_top.sv ----
/*
  Self-checking bench: random back to back operations against a model,
  plus AXI4-Lite register access. Assumes the partner drives op_req.
*/
module dsp_multiply_accumulate_tb_top;
  import mac_pkg::*;
  timeunit 1ns;
  timeprecision 1ns;
  logic mclk = 1'h0;
  logic rst = 1'h1;
  op_req_type op_req;
  logic [ACC_W-1:0] acc_a, acc_b, ea, eb;
  logic [31:0] product, rdata, ep;
  logic [31:0] wdata = 32'h0;
  logic [7:0] awaddr = 8'h0, araddr = 8'h0;
  logic [5:0] status_flags;
  logic [3:0] ef, ev, mk;
  logic [3:0] wstrb = 4'hF;
  logic [1:0] bresp, rresp;
  logic pv, trap, irq, awready, wready, bvalid, arready, rvalid, epv;
  logic awvalid = 1'h0, wvalid = 1'h0, bready = 1'h0, arvalid = 1'h0, rready = 1'h0;
  logic ce_a, ce_b, ls, te_a, te_b;
  int fails = 0, samples_checked = 0, seed = 32'hF073, cyc = 0;

  always #10 mclk = ~mclk;

  dsp_multiply_accumulate dut_u (
    .mclk(mclk), .rst(rst), .op_req(op_req), .acc_a(acc_a), .acc_b(acc_b),
    .product(product), .product_valid(pv), .status_flags(status_flags),
    .arith_trap(trap), .irq(irq), .s_axi_awaddr(awaddr), .s_axi_awvalid(awvalid),
    .s_axi_awready(awready), .s_axi_wdata(wdata), .s_axi_wstrb(wstrb),
    .s_axi_wvalid(wvalid), .s_axi_wready(wready), .s_axi_bresp(bresp),
    .s_axi_bvalid(bvalid), .s_axi_bready(bready), .s_axi_araddr(araddr),
    .s_axi_arvalid(arvalid), .s_axi_arready(arready), .s_axi_rdata(rdata),
    .s_axi_rresp(rresp), .s_axi_rvalid(rvalid), .s_axi_rready(rready)
  );
  core_decode_model core_u (.mclk(mclk), .op_req(op_req));

  // ------------------------------------------------------------
  // Checks and bus tasks
  // ------------------------------------------------------------
  task print_verdict();
    $display("checks %0d mismatches %0d", samples_checked, fails);
    if (fails == 0 && samples_checked > 0)
      $display("Test passed");
    else
      $display("Test failed");
    $finish;
  endtask

  always @(posedge mclk)
  begin
    cyc++;
    if (cyc == 6000)
    begin
      fails++;
      print_verdict();
    end
  end

  task ck(input string n, input logic [39:0] s, input logic [39:0] e);
    samples_checked++;
    if (s !== e)
    begin
      fails++;
      $display("ERROR %s expected %h seen %h", n, e, s);
    end
  endtask

  task automatic axw(input logic [7:0] a, input logic [31:0] d, input logic [1:0] er);
    logic done;
    done = 1'h0;
    @(posedge mclk);
    awaddr <= a;
    wdata <= d;
    awvalid <= 1'h1;
    wvalid <= 1'h1;
    bready <= 1'h1;
    while (!done)
    begin
      @(posedge mclk);
      if (awvalid && awready) awvalid <= 1'h0;
      if (wvalid && wready) wvalid <= 1'h0;
      if (bvalid && bready)
      begin
        done = 1'h1;
        bready <= 1'h0;
        ck("bresp", bresp, er);
      end
    end
  endtask

  task automatic axr(input logic [7:0] a, input logic [31:0] e, input logic [1:0] er);
    logic done;
    done = 1'h0;
    @(posedge mclk);
    araddr <= a;
    arvalid <= 1'h1;
    rready <= 1'h1;
    while (!done)
    begin
      @(posedge mclk);
      if (arvalid && arready) arvalid <= 1'h0;
      if (rvalid && rready)
      begin
        done = 1'h1;
        rready <= 1'h0;
        ck("rdata", rdata, e);
        ck("rresp", rresp, er);
      end
    end
  endtask

  // ------------------------------------------------------------
  // Reference model
  // ------------------------------------------------------------
  task automatic step(input op_req_type r);
    logic [16:0] a17, b17;
    logic signed [33:0] p;
    logic [32:0] m;
    logic [15:0] xa, xb;
    logic [39:0] x, y, res;
    logic [40:0] s;
    logic g, c, k;
    a17 = {r.signed_a & r.opnd_a[15], r.opnd_a};
    b17 = {r.signed_b & r.opnd_b[15], r.opnd_b};
    p = $signed(a17) * $signed(b17);
    xa = {{8{r.signed_a & r.opnd_a[7]}}, r.opnd_a[7:0]};
    xb = {{8{r.signed_b & r.opnd_b[7]}}, r.opnd_b[7:0]};
    epv = r.valid && r.op == OP_INT_PRODUCT;
    if (epv) ep = r.byte_size ? {16'h0, 16'(xa * xb)} : p[31:0];
    if (!r.valid || r.op >= OP_INT_PRODUCT) return;
    m = r.frac ? {p[31:0], 1'h0} : p[32:0];
    y = r.op <= OP_MPY ? {{7{m[32]}}, m} : r.use_shifted ? r.shifted_in : r.data_in;
    x = r.op == OP_MPY || r.op == OP_LOAD ? '0 : r.acc_sel ? eb : ea;
    s = {x[39], x} + (r.op == OP_MSC || r.op == OP_SUB ? ~{y[39], y} + 41'h1 : {y[39], y});
    g = s[39:32] != 8'h0 && s[39:32] != 8'hFF;
    k = s[39:31] != 9'h0 && s[39:31] != 9'h1FF;
    c = (r.acc_sel ? ce_b : ce_a) && (s[40] != s[39] || (!ls && k));
    res = !c ? s[39:0] : ls ? {s[40] ? 8'h80 : 8'h7F, {32{!s[40]}}}
      : {{9{s[40]}}, {31{!s[40]}}};
    if (r.acc_sel) eb = res;
    else ea = res;
    ef[r.acc_sel] = g;
    ef[2 + r.acc_sel] |= c;
    ev = ev | {c & r.acc_sel, c & !r.acc_sel, g & r.acc_sel, g & !r.acc_sel};
  endtask

  task cmp();
    ck("acc_a", acc_a, ea);
    ck("acc_b", acc_b, eb);
    ck("flags", status_flags, {|ef[3:2], |ef[1:0], ef});
    ck("trap", trap, ef[0] & te_a | ef[1] & te_b);
    ck("irq", irq, |(ev & mk));
    ck("pvalid", pv, epv);
    if (epv) ck("product", product, ep);
  endtask

  // Extremes of operands and data mixed in for overflow corners
  function automatic op_req_type rnd();
    op_req_type r;
    logic [31:0] v;
    v = $random(seed);
    r.op = op_type'(v[2:0]);
    {r.acc_sel, r.signed_a, r.signed_b, r.frac, r.byte_size, r.use_shifted} = v[8:3];
    r.valid = v[11:9] != 3'h0;
    r.opnd_a = v[12] ? 16'h8000 : 16'($random(seed));
    r.opnd_b = v[13] ? 16'h8000 : 16'($random(seed));
    r.data_in = v[14] ? {v[15], {39{!v[15]}}} : 40'({$random(seed), $random(seed)});
    r.shifted_in = {{9{v[16]}}, 31'($random(seed))};
    return r;
  endfunction

  // In-range load into A, then unsigned multiply into B that cannot clip
  function automatic op_req_type corner(input int k);
    op_req_type r;
    r = '0;
    r.valid = 1'h1;
    r.op = k == 0 ? OP_LOAD : OP_MPY;
    r.acc_sel = k[0];
    r.opnd_a = 16'h7FFF;
    r.opnd_b = 16'hFFFF;
    r.data_in = 40'hFF_8000_0001;
    return r;
  endfunction

  // ------------------------------------------------------------
  // Main sequence
  // ------------------------------------------------------------
  initial
  begin
    op_req_type r;
    logic [31:0] v;
    {ea, eb, ef, ev, ep, epv} = '0;
    repeat (20) @(posedge mclk);
    rst <= 1'h0;
    axr(OFS_EVENT_MASK, 32'h0, RESP_OKAY);
    axr(8'h40, 32'h0, RESP_SLVERR);
    axw(8'h40, 32'hFFFF_FFFF, RESP_SLVERR);
    ck("irq", irq, 1'h0);
    $display("test reset and unmapped done");
    for (int ph = 0; ph < 4; ph++)
    begin
      v = $random(seed);
      {ce_a, ce_b, ls, te_b, te_a, mk} = {v[7:6], v[4], v[1:0], v[11:8]};
      axw(OFS_CORE_CONTROL, v & 32'hD0, RESP_OKAY);
      axw(OFS_INT_CONTROL_ONE, v & 32'h3, RESP_OKAY);
      axw(OFS_EVENT_MASK, {28'h0, mk}, RESP_OKAY);
      for (int i = 0; i <= 150; i++)
      begin
        // Hand corners lead each phase, random traffic follows
        r = i < 2 ? corner(i) : i < 150 ? rnd() : '0;
        core_u.issue(r);
        #1;
        if (i > 0) cmp();
        step(r);
      end
      axr(OFS_ARITH_FLAGS, {|ef[3:2], |ef[1:0], ef}, RESP_OKAY);
      axr(OFS_ACC_B_HIGH, {{24{eb[39]}}, eb[39:32]}, RESP_OKAY);
      axr(OFS_EVENT_STATUS, ev, RESP_OKAY);
      // Read-only words ignore writes
      axw(OFS_ACC_A_LOW, 32'hFFFF_FFFF, RESP_OKAY);
      axr(OFS_ACC_A_LOW, ea[31:0], RESP_OKAY);
      axr(OFS_ACC_A_HIGH, {{24{ea[39]}}, ea[39:32]}, RESP_OKAY);
      axr(OFS_ACC_B_LOW, eb[31:0], RESP_OKAY);
      axr(OFS_PRODUCT, ep, RESP_OKAY);
      axr(OFS_CORE_CONTROL, v & 32'hD0, RESP_OKAY);
      axr(OFS_INT_CONTROL_ONE, v & 32'h3, RESP_OKAY);
      axw(OFS_EVENT_STATUS, 32'hF, RESP_OKAY);
      axw(OFS_ARITH_FLAGS, 32'hC, RESP_OKAY);
      ev = '0;
      ef[3:2] = '0;
      axr(OFS_EVENT_STATUS, 32'h0, RESP_OKAY);
      ck("flags", status_flags, {1'h0, |ef[1:0], ef});
      $display("test phase %0d done", ph);
    end
    print_verdict();
  end
endmodule
